// file: design/rtc_regs_map.vh
`ifndef RTC_REGS_MAP_VH
`define RTC_REGS_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define RTC_ADDR_TEST_CTRL   32'h400000E0
`define RTC_ADDR_TX_COUNT    32'h400000E4
`define RTC_ADDR_RX_COUNT    32'h400000E8
`define RTC_ADDR_SNAPSHOT    32'h400000EC
`define RTC_ADDR_TIMING      32'h400000F0
`define RTC_ADDR_GROSS_TGT   32'h400000F4
`define RTC_ADDR_FINE_TGT    32'h400000F8
`define RTC_ADDR_SAMPLE      32'h400000FC
`define RTC_ADDR_COEX_CTRL   32'h40000100

// ****************************************************************
// Test control fields
// ****************************************************************
`define RTC_BIT_ENDLESS_RX   31
`define RTC_BIT_RX_CNT_EN    27
`define RTC_BIT_ENDLESS_TX   15
`define RTC_BIT_LEN_SRC      14
`define RTC_BIT_PRBS_TYPE    13
`define RTC_BIT_PLD_SRC      12
`define RTC_BIT_TX_CNT_EN    11
`define RTC_LEN_MSB          8
`define RTC_LEN_LSB          0

// ****************************************************************
// Timing and prefetch fields
// ****************************************************************
`define RTC_BIT_EARLY_ABORT  31
`define RTC_ABORT_MSB        25
`define RTC_ABORT_LSB        16
`define RTC_FETCH_MSB        8
`define RTC_FETCH_LSB        0
`define RTC_RST_EARLY_ABORT  1'h1
`define RTC_RST_ABORT_TIME   10'h1FE
`define RTC_RST_FETCH_TIME   9'h096

// ****************************************************************
// Coexistence fields
// ****************************************************************
`define RTC_RXIND_MSB        21
`define RTC_RXIND_LSB        20
`define RTC_TXIND_MSB        17
`define RTC_TXIND_LSB        16
`define RTC_WTXMSK_MSB       7
`define RTC_WTXMSK_LSB       6
`define RTC_WRXMSK_MSB       5
`define RTC_WRXMSK_LSB       4
`define RTC_BIT_COEXISTENCE_ENABLE      0
`define RTC_RST_WTXMSK       2'h0
`define RTC_RST_WRXMSK       2'h1
`define RTC_RST_IND_MODE     2'h0
`define RTC_IND_NO_PWRUP     2'h0
`define RTC_IND_WITH_PWRUP   2'h1
`define RTC_IND_HIGH_PRIO    2'h2

// ****************************************************************
// Timer target widths
// ****************************************************************
`define RTC_GROSS_W          23
`define RTC_FINE_W           27
`define RTC_BIT_SAMPLE       0

`endif

// file: design/rtc_pkt_counter.v
`timescale 1ns/10ps
`default_nettype none

module rtc_pkt_counter (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        count_en,
  input  wire        pkt_event,
  input  wire        report,
  output reg  [31:0] total
);

  reg  [31:0] live;
  wire [31:0] next_live;

  assign next_live = live + 32'h00000001;

  // ****************************************************************
  // Live count, latched into total on an abort report
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      live  <= 32'h00000000;
      total <= 32'h00000000;
    end else if (report) begin
      // [R21] report includes packet
      total <= (count_en && pkt_event) ? next_live : live;
      live  <= 32'h00000000;
    end else if (count_en && pkt_event) begin
      live <= next_live;
    end
  end

endmodule

`default_nettype wire

// file: design/rtc_stop_decode.v
`timescale 1ns/10ps
`default_nettype none

module rtc_stop_decode (
  input  wire       wlan_active,
  input  wire [1:0] mask,
  output wire       stop_tx,
  output wire       stop_rx
);

  // Mask bit 0 lets WLAN stop local transmit, bit 1 local receive
  assign stop_tx = wlan_active & mask[0];
  assign stop_rx = wlan_active & mask[1];

endmodule

`default_nettype wire

// file: design/rtc_regs.v
// Notes on behaviour
// [R1] Endless receive bit in test mode holds the receive window open.
// [R2] Test mode receive counting enabled; total reported on RF abort.
// [R3] Receive total counts only packets free of sync and CRC errors.
// [R4] Endless transmit bit in test mode sends payload without end.
// [R5] Length source clear uses descriptor size, set uses test length.
// [R6] Pseudo-random type selects PRBS9 when 0, PRBS15 when 1.
// [R7] Payload source selects control structure or PRBS generator.
// [R8] Transmit counting enabled in test mode; total reported on abort.
// [R9] Nine-bit test length applies only when length source is 1.
// [R10] Early abort enable bit, enabled out of reset.
// [R11] Ten-bit forced abort instant, reset 0x1FE microseconds.
// [R12] Nine-bit table fetch instant, reset 0x96 microseconds.
// [R13] Coarse event when target equals counter 26:4 and 3:0 zero.
// [R14] Precise event when target equals the whole counter.
// [R15] Writing 1 to snapshot bit captures counter; bit self-clears.
// [R16] Receive indication mode: no power-up, power-up, priority.
// [R17] Transmit indication mode: no power-up, power-up, priority.
// [R18] WLAN transmit mask stops nothing, local tx, local rx or both.
// [R19] WLAN receive mask likewise; reset value stops local transmit.
// [R20] Coexistence enable switches the interface on; off at reset.
// [R21] Counters step by one per packet and hold between reports.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs_map.vh"

module rtc_regs (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [31:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        rf_test_mode,
  input  wire        rf_abort,
  input  wire        rx_pkt_done,
  input  wire        rx_sync_err,
  input  wire        rx_crc_err,
  input  wire        tx_pkt_done,
  input  wire [8:0]  desc_payload_length,
  input  wire [26:0] slot_time_counter,
  input  wire        tx_enable,
  input  wire        tx_active,
  input  wire        rx_enable,
  input  wire        rx_correlating,
  input  wire        tx_high_prio,
  input  wire        rx_high_prio,
  input  wire        wlan_tx,
  input  wire        wlan_rx,
  output reg         endless_receive_window,
  output reg         endless_transmit_payload,
  output reg  [8:0]  tx_payload_length,
  output reg         pseudo_random_type,
  output reg         payload_source_select,
  output reg         early_abort_enable,
  output reg  [9:0]  forced_abort_instant,
  output reg  [8:0]  table_fetch_instant,
  output reg         coarse_timer_event,
  output reg         precise_timer_event,
  output reg         coex_tx_indication,
  output reg         coex_rx_indication,
  output reg         stop_local_tx,
  output reg         stop_local_rx
);

  // ****************************************************************
  // Software-visible state
  // ****************************************************************
  reg         endless_rx_bit;
  reg         receive_count_enable;
  reg         endless_tx_bit;
  reg         length_source_select;
  reg         prbs_type_bit;
  reg         payload_src_bit;
  reg         transmit_count_enable;
  reg  [8:0]  test_packet_length;
  reg  [22:0] coarse_target_value;
  reg  [26:0] precise_target_value;
  reg  [26:0] counter_snapshot;
  reg         counter_snapshot_trigger;
  reg  [1:0]  receive_indication_mode;
  reg  [1:0]  transmit_indication_mode;
  reg  [1:0]  coex_transmit_mask;
  reg  [1:0]  coex_receive_mask;
  reg         coexistence_enable;
  reg         coarse_match_q;
  reg         precise_match_q;

  wire [31:0] sent_packet_total;
  wire [31:0] good_packet_total;
  wire        wr_ctrl;
  wire        wr_timing;
  wire        wr_gross;
  wire        wr_fine;
  wire        wr_sample;
  wire        wr_coex;
  wire        rx_good;
  wire        coarse_match;
  wire        precise_match;
  wire        wtx_stop_tx;
  wire        wtx_stop_rx;
  wire        wrx_stop_tx;
  wire        wrx_stop_rx;
  reg         next_tx_ind;
  reg         next_rx_ind;
  reg  [31:0] next_rdata;

  assign wr_ctrl   = reg_wr && (reg_addr == `RTC_ADDR_TEST_CTRL);
  assign wr_timing = reg_wr && (reg_addr == `RTC_ADDR_TIMING);
  assign wr_gross  = reg_wr && (reg_addr == `RTC_ADDR_GROSS_TGT);
  assign wr_fine   = reg_wr && (reg_addr == `RTC_ADDR_FINE_TGT);
  assign wr_sample = reg_wr && (reg_addr == `RTC_ADDR_SAMPLE);
  assign wr_coex   = reg_wr && (reg_addr == `RTC_ADDR_COEX_CTRL);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      endless_rx_bit        <= 1'h0;
      receive_count_enable  <= 1'h0;
      endless_tx_bit        <= 1'h0;
      length_source_select  <= 1'h0;
      prbs_type_bit         <= 1'h0;
      payload_src_bit       <= 1'h0;
      transmit_count_enable <= 1'h0;
      test_packet_length    <= 9'h000;
    end else if (wr_ctrl) begin
      endless_rx_bit        <= reg_wdata[`RTC_BIT_ENDLESS_RX];
      receive_count_enable  <= reg_wdata[`RTC_BIT_RX_CNT_EN];
      endless_tx_bit        <= reg_wdata[`RTC_BIT_ENDLESS_TX];
      length_source_select  <= reg_wdata[`RTC_BIT_LEN_SRC];
      prbs_type_bit         <= reg_wdata[`RTC_BIT_PRBS_TYPE];
      payload_src_bit       <= reg_wdata[`RTC_BIT_PLD_SRC];
      transmit_count_enable <= reg_wdata[`RTC_BIT_TX_CNT_EN];
      test_packet_length    <= reg_wdata[`RTC_LEN_MSB:`RTC_LEN_LSB];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      // [R10] enabled at reset
      early_abort_enable   <= `RTC_RST_EARLY_ABORT;
      // [R11] abort instant reset
      forced_abort_instant <= `RTC_RST_ABORT_TIME;
      // [R12] fetch instant reset
      table_fetch_instant  <= `RTC_RST_FETCH_TIME;
    end else if (wr_timing) begin
      early_abort_enable   <= reg_wdata[`RTC_BIT_EARLY_ABORT];
      forced_abort_instant <= reg_wdata[`RTC_ABORT_MSB:`RTC_ABORT_LSB];
      table_fetch_instant  <= reg_wdata[`RTC_FETCH_MSB:`RTC_FETCH_LSB];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      coarse_target_value  <= 23'h000000;
      precise_target_value <= 27'h0000000;
    end else begin
      if (wr_gross) begin
        coarse_target_value <= reg_wdata[`RTC_GROSS_W-1:0];
      end
      if (wr_fine) begin
        precise_target_value <= reg_wdata[`RTC_FINE_W-1:0];
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      receive_indication_mode  <= `RTC_RST_IND_MODE;
      transmit_indication_mode <= `RTC_RST_IND_MODE;
      coex_transmit_mask       <= `RTC_RST_WTXMSK;
      // [R19] default stops local tx
      coex_receive_mask        <= `RTC_RST_WRXMSK;
      // [R20] coexistence off at reset
      coexistence_enable       <= 1'h0;
    end else if (wr_coex) begin
      receive_indication_mode  <= reg_wdata[`RTC_RXIND_MSB:`RTC_RXIND_LSB];
      transmit_indication_mode <= reg_wdata[`RTC_TXIND_MSB:`RTC_TXIND_LSB];
      coex_transmit_mask       <= reg_wdata[`RTC_WTXMSK_MSB:`RTC_WTXMSK_LSB];
      coex_receive_mask        <= reg_wdata[`RTC_WRXMSK_MSB:`RTC_WRXMSK_LSB];
      coexistence_enable       <= reg_wdata[`RTC_BIT_COEXISTENCE_ENABLE];
    end
  end

  // ****************************************************************
  // Counter snapshot
  // ****************************************************************
  // [R15] capture then self-clear
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      counter_snapshot_trigger <= 1'h0;
      counter_snapshot         <= 27'h0000000;
    end else begin
      if (counter_snapshot_trigger) begin
        counter_snapshot <= slot_time_counter;
      end
      if (wr_sample && reg_wdata[`RTC_BIT_SAMPLE]) begin
        counter_snapshot_trigger <= 1'h1;
      end else begin
        counter_snapshot_trigger <= 1'h0;
      end
    end
  end

  // ****************************************************************
  // Test packet counters
  // ****************************************************************
  // [R3] only error-free packets
  assign rx_good = rx_pkt_done && !rx_sync_err && !rx_crc_err;

  // [R2] receive count and report
  rtc_pkt_counter u_rx_count (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .count_en  (rf_test_mode && receive_count_enable),
    .pkt_event (rx_good),
    .report    (rf_abort),
    .total     (good_packet_total)
  );

  // [R8] transmit count and report
  rtc_pkt_counter u_tx_count (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .count_en  (rf_test_mode && transmit_count_enable),
    .pkt_event (tx_pkt_done),
    .report    (rf_abort),
    .total     (sent_packet_total)
  );

  // ****************************************************************
  // Test mode controls to the sequencer
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      endless_receive_window   <= 1'h0;
      endless_transmit_payload <= 1'h0;
      tx_payload_length        <= 9'h000;
      pseudo_random_type       <= 1'h0;
      payload_source_select    <= 1'h0;
    end else begin
      // [R1] endless receive
      endless_receive_window   <= rf_test_mode && endless_rx_bit;
      // [R4] endless transmit
      endless_transmit_payload <= rf_test_mode && endless_tx_bit;
      // [R5] [R9] length source
      if (rf_test_mode && length_source_select) begin
        tx_payload_length <= test_packet_length;
      end else begin
        tx_payload_length <= desc_payload_length;
      end
      // [R6] PRBS type
      pseudo_random_type    <= rf_test_mode && prbs_type_bit;
      // [R7] payload source
      payload_source_select <= rf_test_mode && payload_src_bit;
    end
  end

  // ****************************************************************
  // Timer target comparators
  // ****************************************************************
  // [R13] coarse match
  assign coarse_match = (coarse_target_value == slot_time_counter[26:4])
                     && (slot_time_counter[3:0] == 4'h0);
  // [R14] precise match
  assign precise_match = (precise_target_value == slot_time_counter);

  // One pulse on entry to a match, however long the counter dwells
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      coarse_match_q      <= 1'h0;
      precise_match_q     <= 1'h0;
      coarse_timer_event  <= 1'h0;
      precise_timer_event <= 1'h0;
    end else begin
      coarse_match_q      <= coarse_match;
      precise_match_q     <= precise_match;
      coarse_timer_event  <= coarse_match && !coarse_match_q;
      precise_timer_event <= precise_match && !precise_match_q;
    end
  end

  // ****************************************************************
  // WLAN coexistence
  // ****************************************************************
  // [R18] WLAN transmit mask
  rtc_stop_decode u_wtx_stop (
    .wlan_active (wlan_tx),
    .mask        (coex_transmit_mask),
    .stop_tx     (wtx_stop_tx),
    .stop_rx     (wtx_stop_rx)
  );

  // [R19] WLAN receive mask
  rtc_stop_decode u_wrx_stop (
    .wlan_active (wlan_rx),
    .mask        (coex_receive_mask),
    .stop_tx     (wrx_stop_tx),
    .stop_rx     (wrx_stop_rx)
  );

  // [R17] transmit indication
  always @* begin
    case (transmit_indication_mode)
      `RTC_IND_NO_PWRUP:   next_tx_ind = tx_active;
      `RTC_IND_WITH_PWRUP: next_tx_ind = tx_enable;
      `RTC_IND_HIGH_PRIO:  next_tx_ind = tx_enable && tx_high_prio;
      default:             next_tx_ind = 1'h0;
    endcase
  end

  // [R16] receive indication
  always @* begin
    case (receive_indication_mode)
      `RTC_IND_NO_PWRUP:   next_rx_ind = rx_correlating;
      `RTC_IND_WITH_PWRUP: next_rx_ind = rx_enable;
      `RTC_IND_HIGH_PRIO:  next_rx_ind = rx_enable && rx_high_prio;
      default:             next_rx_ind = 1'h0;
    endcase
  end

  // [R20] gate by coexistence enable
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      coex_tx_indication <= 1'h0;
      coex_rx_indication <= 1'h0;
      stop_local_tx      <= 1'h0;
      stop_local_rx      <= 1'h0;
    end else begin
      coex_tx_indication <= coexistence_enable && next_tx_ind;
      coex_rx_indication <= coexistence_enable && next_rx_ind;
      stop_local_tx <= coexistence_enable && (wtx_stop_tx || wrx_stop_tx);
      stop_local_rx <= coexistence_enable && (wtx_stop_rx || wrx_stop_rx);
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `RTC_ADDR_TEST_CTRL: begin
        next_rdata[`RTC_BIT_ENDLESS_RX]        = endless_rx_bit;
        next_rdata[`RTC_BIT_RX_CNT_EN]         = receive_count_enable;
        next_rdata[`RTC_BIT_ENDLESS_TX]        = endless_tx_bit;
        next_rdata[`RTC_BIT_LEN_SRC]           = length_source_select;
        next_rdata[`RTC_BIT_PRBS_TYPE]         = prbs_type_bit;
        next_rdata[`RTC_BIT_PLD_SRC]           = payload_src_bit;
        next_rdata[`RTC_BIT_TX_CNT_EN]         = transmit_count_enable;
        next_rdata[`RTC_LEN_MSB:`RTC_LEN_LSB]  = test_packet_length;
      end
      `RTC_ADDR_TX_COUNT: next_rdata = sent_packet_total;
      `RTC_ADDR_RX_COUNT: next_rdata = good_packet_total;
      `RTC_ADDR_SNAPSHOT: next_rdata[26:0] = counter_snapshot;
      `RTC_ADDR_TIMING: begin
        next_rdata[`RTC_BIT_EARLY_ABORT]         = early_abort_enable;
        next_rdata[`RTC_ABORT_MSB:`RTC_ABORT_LSB] = forced_abort_instant;
        next_rdata[`RTC_FETCH_MSB:`RTC_FETCH_LSB] = table_fetch_instant;
      end
      `RTC_ADDR_GROSS_TGT: next_rdata[22:0] = coarse_target_value;
      `RTC_ADDR_FINE_TGT:  next_rdata[26:0] = precise_target_value;
      `RTC_ADDR_COEX_CTRL: begin
        next_rdata[`RTC_RXIND_MSB:`RTC_RXIND_LSB]   = receive_indication_mode;
        next_rdata[`RTC_TXIND_MSB:`RTC_TXIND_LSB]   = transmit_indication_mode;
        next_rdata[`RTC_WTXMSK_MSB:`RTC_WTXMSK_LSB] = coex_transmit_mask;
        next_rdata[`RTC_WRXMSK_MSB:`RTC_WRXMSK_LSB] = coex_receive_mask;
        next_rdata[`RTC_BIT_COEXISTENCE_ENABLE]                = coexistence_enable;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// file: tb/rtc_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_regs_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [31:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rf_test_mode,
  input wire logic [8:0]  desc_payload_length,
  input wire logic [26:0] slot_time_counter,
  input wire logic        tx_enable,
  input wire logic        tx_active,
  input wire logic        wlan_tx,
  input wire logic        wlan_rx,
  input wire logic        endless_receive_window,
  input wire logic        endless_transmit_payload,
  input wire logic [8:0]  tx_payload_length,
  input wire logic        early_abort_enable,
  input wire logic [9:0]  forced_abort_instant,
  input wire logic [8:0]  table_fetch_instant,
  input wire logic        coarse_timer_event,
  input wire logic        precise_timer_event,
  input wire logic        coex_tx_indication,
  input wire logic        stop_local_tx,
  input wire logic        stop_local_rx
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_gate;
    !$past(rf_test_mode) |-> !endless_receive_window
      && !endless_transmit_payload;
  endproperty
  a_gate: assert property (p_gate) else $error("test bit outside test");
  property p_len;
    $past(rst_b) && !$past(rf_test_mode)
      |-> tx_payload_length == $past(desc_payload_length);
  endproperty
  a_len: assert property (p_len) else $error("length not descriptor");
  property p_rst;
    $rose(rst_b) |-> early_abort_enable && forced_abort_instant == 10'h1FE
      && table_fetch_instant == 9'h096;
  endproperty
  a_rst: assert property (p_rst) else $error("timing reset value");
  property p_coarse;
    coarse_timer_event |-> $past(slot_time_counter[3:0]) == 4'h0
      || $past(slot_time_counter[3:0], 2) == 4'h0;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse low bits");
  property p_cpulse;
    coarse_timer_event |=> !coarse_timer_event;
  endproperty
  a_cpulse: assert property (p_cpulse) else $error("coarse repeat");
  property p_fpulse;
    precise_timer_event |=> !precise_timer_event;
  endproperty
  a_fpulse: assert property (p_fpulse) else $error("precise repeat");
  property p_counter_snapshot_trigger;
    $past(reg_rd) && $past(reg_addr) == 32'h400000FC |-> reg_rdata == 32'h0;
  endproperty
  a_counter_snapshot_trigger: assert property (p_counter_snapshot_trigger) else $error("trigger reads nonzero");
  property p_stop;
    !$past(wlan_tx) && !$past(wlan_rx) |-> !stop_local_tx && !stop_local_rx;
  endproperty
  a_stop: assert property (p_stop) else $error("stop without wlan");
  property p_ind;
    coex_tx_indication |-> $past(tx_active || tx_enable);
  endproperty
  a_ind: assert property (p_ind) else $error("tx indication no cause");
  c_coarse: cover property (coarse_timer_event);
  c_fine: cover property (precise_timer_event);
  c_stop: cover property (stop_local_tx && stop_local_rx);
endmodule
bind rtc_regs rtc_regs_monitor u_mon (.*);
`default_nettype wire

// file: tb/rtc_coex_partner.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_coex_partner (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic want_tx,
  input  wire logic want_rx,
  output var logic  wlan_tx,
  output var logic  wlan_rx
);
  // Arbiter activity follows its own requests one cycle later
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      wlan_tx <= 1'b0;
      wlan_rx <= 1'b0;
    end else begin
      wlan_tx <= want_tx;
      wlan_rx <= want_rx;
    end
  end
endmodule
`default_nettype wire

// file: tb/rtc_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_regs_tb;
  logic        clk_sys, rst_b, reg_wr, reg_rd, rf_test_mode, rf_abort;
  logic [31:0] reg_addr, reg_wdata, reg_rdata;
  logic        rx_pkt_done, rx_sync_err, rx_crc_err, tx_pkt_done;
  logic [8:0]  desc_payload_length, tx_payload_length, table_fetch_instant;
  logic [26:0] slot_time_counter;
  logic        tx_enable, tx_active, rx_enable, rx_correlating;
  logic        tx_high_prio, rx_high_prio, wlan_tx, wlan_rx, want_tx, want_rx;
  logic        endless_receive_window, endless_transmit_payload;
  logic        pseudo_random_type, payload_source_select, early_abort_enable;
  logic [9:0]  forced_abort_instant;
  logic        coarse_timer_event, precise_timer_event, coex_tx_indication;
  logic        coex_rx_indication, stop_local_tx, stop_local_rx;
  int          bad_count, n_compared;
  wire [31:0]  tmode = {19'h0, endless_receive_window, endless_transmit_payload,
    pseudo_random_type, payload_source_select, tx_payload_length};
  int          n_coarse = 0;
  int          n_fine = 0;

  rtc_regs DUT (.*);
  rtc_coex_partner u_wlan (.*);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_coarse <= n_coarse + int'(coarse_timer_event);
    n_fine <= n_fine + int'(precise_timer_event);
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, exp, input string nm);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask
  task automatic pkt(input logic t, se, ce);
    @(posedge clk_sys);
    {tx_pkt_done, rx_pkt_done, rx_sync_err, rx_crc_err} <= {t, !t, se, ce};
    @(posedge clk_sys);
    {tx_pkt_done, rx_pkt_done, rx_sync_err, rx_crc_err} <= 4'h0;
  endtask
  task automatic abort_run;
    @(posedge clk_sys);
    rf_abort <= 1'b1;
    @(posedge clk_sys);
    rf_abort <= 1'b0;
  endtask
  function automatic logic ind(input logic [1:0] m, input logic a, e, h);
    return (m == 2'h0) ? a : (m == 2'h1) ? e : (m == 2'h2) ? (e & h) : 1'b0;
  endfunction

  task automatic t_reset;
    rdc(32'h400000E0, 32'h0, "test ctrl");
    rdc(32'h400000E4, 32'h0, "tx total");
    rdc(32'h400000E8, 32'h0, "rx total");
    rdc(32'h400000F0, 32'h81FE0096, "timing");
    rdc(32'h400000F4, 32'h0, "coarse tgt");
    rdc(32'h400000F8, 32'h0, "fine tgt");
    rdc(32'h40000100, 32'h00000010, "coex");
    rdc(32'h40000104, 32'h0, "unmapped");
    wr(32'h400000F0, 32'h02AB0155);
    rdc(32'h400000F0, 32'h02AB0155, "timing rb");
    chk("timing out", {12'h0, early_abort_enable, forced_abort_instant,
      table_fetch_instant}, {12'h0, 1'h0, 10'h2AB, 9'h155});
  endtask
  task automatic t_test_ctrl;
    wr(32'h400000E0, 32'h8000F1A5);
    rdc(32'h400000E0, 32'h8000F1A5, "ctrl rb");
    settle(2);
    chk("outside test", tmode, {23'h0, 9'h033});
    rf_test_mode <= 1'b1;
    settle(2);
    chk("in test", tmode, {19'h0, 4'hF, 9'h1A5});
    wr(32'h400000E0, 32'h000001A5);
    settle(2);
    chk("desc len", tmode, {23'h0, 9'h033});
  endtask
  task automatic t_counters;
    wr(32'h400000E0, 32'h08000800);
    repeat (3) pkt(1'b1, 1'b0, 1'b0);
    pkt(1'b0, 1'b0, 1'b0);
    pkt(1'b0, 1'b1, 1'b0);
    pkt(1'b0, 1'b0, 1'b1);
    pkt(1'b0, 1'b0, 1'b0);
    abort_run;
    rdc(32'h400000E4, 32'h3, "tx total");
    rdc(32'h400000E8, 32'h2, "rx total");
    pkt(1'b1, 1'b0, 1'b0);
    wr(32'h400000E4, 32'hFFFFFFFF);
    rdc(32'h400000E4, 32'h3, "tx held");
    abort_run;
    rdc(32'h400000E4, 32'h1, "tx rerun");
    wr(32'h400000E0, 32'h0);
    pkt(1'b1, 1'b0, 1'b0);
    pkt(1'b0, 1'b0, 1'b0);
    abort_run;
    rdc(32'h400000E4, 32'h0, "tx off");
    rdc(32'h400000E8, 32'h0, "rx off");
  endtask
  task automatic t_timers;
    int c0;
    int f0;
    wr(32'h400000F8, 32'h00000123);
    wr(32'h400000F4, 32'h00000ABC);
    c0 = n_coarse;
    f0 = n_fine;
    slot_time_counter <= 27'h000ABC1;
    settle(5);
    chk("coarse low", n_coarse - c0, 32'h0);
    slot_time_counter <= 27'h000ABC0;
    settle(6);
    chk("coarse hit", n_coarse - c0, 32'h1);
    slot_time_counter <= 27'h0000123;
    settle(6);
    chk("fine hit", n_fine - f0, 32'h1);
  endtask
  task automatic t_sample;
    slot_time_counter <= 27'h1234567;
    wr(32'h400000FC, 32'h1);
    settle(2);
    slot_time_counter <= 27'h7654321;
    rdc(32'h400000EC, 32'h01234567, "snapshot");
    rdc(32'h400000FC, 32'h0, "trigger");
  endtask
  task automatic t_coex;
    logic [7:0] v;
    logic [7:0] k;
    logic       en;
    for (int i = 0; i < 512; i++) begin
      v = i[7:0];
      k = v * 8'd37;
      en = i[8];
      {rx_high_prio, rx_enable, rx_correlating} <= k[5:3];
      {tx_high_prio, tx_enable, tx_active} <= k[2:0];
      {want_rx, want_tx} <= k[7:6];
      wr(32'h40000100, {10'h0, v[3:2], 2'h0, v[1:0], 8'h0, v[5:4], v[7:6],
        3'h0, en});
      settle(4);
      chk("tx ind", {31'h0, coex_tx_indication},
        {31'h0, en & ind(v[1:0], k[0], k[1], k[2])});
      chk("rx ind", {31'h0, coex_rx_indication},
        {31'h0, en & ind(v[3:2], k[3], k[4], k[5])});
      chk("stop tx", {31'h0, stop_local_tx},
        {31'h0, en & ((k[6] & v[4]) | (k[7] & v[6]))});
      chk("stop rx", {31'h0, stop_local_rx},
        {31'h0, en & ((k[6] & v[5]) | (k[7] & v[7]))});
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    final_report;
  end
  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, rf_test_mode, rf_abort} = 4'h0;
    {rx_pkt_done, rx_sync_err, rx_crc_err, tx_pkt_done} = 4'h0;
    {tx_enable, tx_active, rx_enable, rx_correlating} = 4'h0;
    {tx_high_prio, rx_high_prio, want_tx, want_rx} = 4'h0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    desc_payload_length = 9'h033;
    slot_time_counter = 27'h5555555;
    bad_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset;
    t_test_ctrl;
    t_counters;
    t_timers;
    t_sample;
    t_coex;
    final_report;
  end
endmodule
`default_nettype wire
